//--- src/psf_pkg.sv
// Purpose: Shared constants and types of the processor status flag block
// Assumes: 8-bit core datapath, APB register access with 32-bit data
// Notes: Flag bit positions, offsets, reset values and op codes live here

package psf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	// Printed register index of the system status flags register
	localparam logic [7:0] STATUS_FLAGS_INDEX = 8'hd5;
	// Byte address: index times four
	localparam logic [11:0] STATUS_FLAGS_ADDR = {2'b00, STATUS_FLAGS_INDEX, 2'b00};
	// Value after reset (undefined in the part, held at zero here)
	localparam logic [7:0] STATUS_FLAGS_RESET = 8'h00;
	// Least address width accepted: the width of the register map byte address, though ten bits reach the register
	localparam int PADDR_MIN_WIDTH = 12;

	// ----------------------------------------------------------------
	// Flag bit positions
	// ----------------------------------------------------------------
	localparam int BIT_CARRY = 7;
	localparam int BIT_ZERO = 6;
	localparam int BIT_SIGN = 5;
	localparam int BIT_OVERFLOW = 4;
	localparam int BIT_DEC_ADJUST = 3;
	localparam int BIT_HALF_CARRY = 2;
	localparam int BIT_FAST_INT = 1;
	localparam int BIT_BANK = 0;

	// ----------------------------------------------------------------
	// Banked control register region
	// ----------------------------------------------------------------
	localparam logic [7:0] BANKED_REGION_BASE = 8'he0;

	// ----------------------------------------------------------------
	// Jump condition select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] COND_ALWAYS = 3'h0;
	localparam logic [2:0] COND_CARRY = 3'h1;
	localparam logic [2:0] COND_ZERO = 3'h2;
	localparam logic [2:0] COND_SIGN = 3'h3;
	localparam logic [2:0] COND_OVERFLOW = 3'h4;

	// ----------------------------------------------------------------
	// BCD correction constants
	// ----------------------------------------------------------------
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
	localparam logic [3:0] BCD_CORRECTION = 4'h6;

	// Datapath operations issued by the execution logic
	typedef enum logic [3:0] {
		OP_ADD,
		OP_ADD_CARRY,
		OP_SUB,
		OP_SUB_CARRY,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_BIT_TEST,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_SHIFT_RIGHT_ARITH,
		OP_DECIMAL_ADJUST
	} psf_op_type;

endpackage : psf_pkg

//--- src/psf_status_flags.sv
// Purpose: Status flag register and flag datapath of the 8-bit core
// Assumes: Execution strobes come from logic on clk_sys, one cycle each
// Notes: APB slave answers with one wait-free access phase per transfer

`timescale 1ns/1ps
`default_nettype none

// How it works
// - Carry set on carry out or borrow
// - Zero flag follows zero result
// - Sign flag copies result bit seven
// - Overflow on signed byte range overflow
// - Logical operations clear overflow
// - Decimal-adjust bit records add or subtract
// - Half carry from bit three or four
// - Decimal adjust uses half carry for BCD
// - Fast bit set on entry, cleared on return
// - Fast bit blocks interrupts, picks fast return
// - Bank bit picks bank for upper registers
// - Bank select instructions clear or set bank
// - Jumps test carry, zero, sign, overflow
// - Banking covers only addresses E0 to FF
module psf_status_flags #(
	parameter int PADDR_WIDTH = 12
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Execution logic
	input wire logic exec_valid,
	input wire psf_pkg::psf_op_type exec_op,
	input wire logic [7:0] operand_a,
	input wire logic [7:0] operand_b,
	input wire logic flags_load,
	input wire logic [7:0] flags_load_data,
	input wire logic select_bank_zero_instr,
	input wire logic select_bank_one_instr,
	input wire logic fast_int_enter,
	input wire logic interrupt_return_instr,
	input wire logic [2:0] cond_sel,
	input wire logic cond_invert,
	input wire logic [7:0] reg_addr,
	input wire logic reg_addr_valid,
	// Results
	output logic [7:0] result,
	output logic [7:0] status_flags,
	output logic jump_taken,
	output logic irq_inhibit,
	output logic fast_return,
	output logic normal_return,
	output logic bank0_sel,
	output logic bank1_sel
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (PADDR_WIDTH < psf_pkg::PADDR_MIN_WIDTH) begin : g_bad_width
		$error("PADDR_WIDTH too narrow for the register map");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0] flags_q; // System status flags register
	logic [7:0] flags_d;
	logic [7:0] result_q; // Last datapath result
	logic [7:0] result_d;
	logic [8:0] wide; // Nine-bit sum or difference
	logic [4:0] half; // Low nibble sum or difference
	logic [7:0] res; // Result of the current operation
	logic [7:0] adj; // BCD correction amount
	logic cin; // Carry into the operation
	logic apb_hit; // Address decodes to the flag register
	logic apb_wr_bank; // Software write of the bank bit
	logic pready_q; // APB ready
	logic pready_d;
	logic pslverr_q; // APB error for unmapped address
	logic pslverr_d;
	logic [31:0] prdata_q; // APB read data
	logic [31:0] prdata_d;
	logic jump_q; // Condition result
	logic jump_d;
	logic fast_ret_q; // Fast return pulse
	logic fast_ret_d;
	logic norm_ret_q; // Normal return pulse
	logic norm_ret_d;
	logic bank0_q; // Bank 0 register selected
	logic bank0_d;
	logic bank1_q; // Bank 1 register selected
	logic bank1_d;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Full address match on the flag register word
	assign apb_hit = (paddr == PADDR_WIDTH'(psf_pkg::STATUS_FLAGS_ADDR));
	// Write completes in the access phase while ready is high
	assign apb_wr_bank = psel && penable && pready_q && pwrite && apb_hit
		&& pstrb[0];

	// ----------------------------------------------------------------
	// Flag datapath
	// ----------------------------------------------------------------
	// Next flags and result
	always_comb begin
		flags_d = flags_q;
		result_d = result_q;
		wide = 9'h000;
		half = 5'h00;
		res = 8'h00;
		adj = 8'h00;
		cin = 1'b0;
		// Carry in only for the with-carry forms
		if (exec_op == psf_pkg::OP_ADD_CARRY ||
			exec_op == psf_pkg::OP_SUB_CARRY) begin
			cin = flags_q[psf_pkg::BIT_CARRY];
		end
		if (exec_valid) begin
			case (exec_op)
				// Additions
				psf_pkg::OP_ADD, psf_pkg::OP_ADD_CARRY: begin
					wide = {1'b0, operand_a} + {1'b0, operand_b} + {8'h00, cin};
					half = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]}
						+ {4'h0, cin};
					res = wide[7:0];
					flags_d[psf_pkg::BIT_CARRY] = wide[8];
					flags_d[psf_pkg::BIT_OVERFLOW] = (operand_a[7] == operand_b[7])
						&& (res[7] != operand_a[7]);
					flags_d[psf_pkg::BIT_DEC_ADJUST] = 1'b0;
					flags_d[psf_pkg::BIT_HALF_CARRY] = half[4];
				end
				// Subtractions
				psf_pkg::OP_SUB, psf_pkg::OP_SUB_CARRY: begin
					wide = {1'b0, operand_a} - {1'b0, operand_b} - {8'h00, cin};
					half = {1'b0, operand_a[3:0]} - {1'b0, operand_b[3:0]}
						- {4'h0, cin};
					res = wide[7:0];
					flags_d[psf_pkg::BIT_CARRY] = wide[8];
					flags_d[psf_pkg::BIT_OVERFLOW] = (operand_a[7] != operand_b[7])
						&& (res[7] != operand_a[7]);
					flags_d[psf_pkg::BIT_DEC_ADJUST] = 1'b1;
					flags_d[psf_pkg::BIT_HALF_CARRY] = half[4];
				end
				// Logical operations
				psf_pkg::OP_AND, psf_pkg::OP_OR, psf_pkg::OP_XOR: begin
					if (exec_op == psf_pkg::OP_AND) begin
						res = operand_a & operand_b;
					end else if (exec_op == psf_pkg::OP_OR) begin
						res = operand_a | operand_b;
					end else begin
						res = operand_a ^ operand_b;
					end
					flags_d[psf_pkg::BIT_OVERFLOW] = 1'b0;
				end
				// Bit test: flags only, result kept
				psf_pkg::OP_BIT_TEST: begin
					res = operand_a & operand_b;
					flags_d[psf_pkg::BIT_OVERFLOW] = 1'b0;
				end
				// Rotate left through carry
				psf_pkg::OP_ROTATE_LEFT_CARRY: begin
					res = {operand_a[6:0], flags_q[psf_pkg::BIT_CARRY]};
					flags_d[psf_pkg::BIT_CARRY] = operand_a[7];
					flags_d[psf_pkg::BIT_OVERFLOW] = res[7] ^ operand_a[7];
				end
				// Rotate right through carry
				psf_pkg::OP_ROTATE_RIGHT_CARRY: begin
					res = {flags_q[psf_pkg::BIT_CARRY], operand_a[7:1]};
					flags_d[psf_pkg::BIT_CARRY] = operand_a[0];
					flags_d[psf_pkg::BIT_OVERFLOW] = res[7] ^ operand_a[7];
				end
				// Arithmetic shift right keeps the sign
				psf_pkg::OP_SHIFT_RIGHT_ARITH: begin
					res = {operand_a[7], operand_a[7:1]};
					flags_d[psf_pkg::BIT_CARRY] = operand_a[0];
					flags_d[psf_pkg::BIT_OVERFLOW] = 1'b0;
				end
				// BCD correction of the previous add or subtract
				psf_pkg::OP_DECIMAL_ADJUST: begin
					if (!flags_q[psf_pkg::BIT_DEC_ADJUST]) begin
						// After an addition
						if (flags_q[psf_pkg::BIT_HALF_CARRY] ||
							operand_a[3:0] > psf_pkg::BCD_DIGIT_MAX) begin
							adj[3:0] = psf_pkg::BCD_CORRECTION;
						end
						if (flags_q[psf_pkg::BIT_CARRY] ||
							operand_a > psf_pkg::BCD_BYTE_MAX) begin
							adj[7:4] = psf_pkg::BCD_CORRECTION;
							flags_d[psf_pkg::BIT_CARRY] = 1'b1;
						end
						res = operand_a + adj;
					end else begin
						// After a subtraction
						if (flags_q[psf_pkg::BIT_HALF_CARRY]) begin
							adj[3:0] = psf_pkg::BCD_CORRECTION;
						end
						if (flags_q[psf_pkg::BIT_CARRY]) begin
							adj[7:4] = psf_pkg::BCD_CORRECTION;
						end
						res = operand_a - adj;
					end
				end
				default: begin
					res = result_q;
				end
			endcase
			// Zero and sign for every flag-setting operation
			flags_d[psf_pkg::BIT_ZERO] = (res == 8'h00);
			flags_d[psf_pkg::BIT_SIGN] = res[7];
			// Bit test leaves the result register alone
			if (exec_op != psf_pkg::OP_BIT_TEST) begin
				result_d = res;
			end
		end
		// Whole register restored from the stack on return
		if (flags_load) begin
			flags_d = flags_load_data;
		end
		// Bank bit: software write, instructions win
		if (apb_wr_bank) begin
			flags_d[psf_pkg::BIT_BANK] = pwdata[0];
		end
		if (select_bank_zero_instr) begin
			flags_d[psf_pkg::BIT_BANK] = 1'b0;
		end
		if (select_bank_one_instr) begin
			flags_d[psf_pkg::BIT_BANK] = 1'b1;
		end
		// Fast bit: clear on return, entry wins
		if (interrupt_return_instr && flags_q[psf_pkg::BIT_FAST_INT]) begin
			flags_d[psf_pkg::BIT_FAST_INT] = 1'b0;
		end
		if (fast_int_enter) begin
			flags_d[psf_pkg::BIT_FAST_INT] = 1'b1;
		end
	end

	// Flag and result registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flags_q <= psf_pkg::STATUS_FLAGS_RESET;
			result_q <= 8'h00;
		end else begin
			flags_q <= flags_d;
			result_q <= result_d;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Ready rises after setup, drops after the access
	always_comb begin
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		if (psel && !penable) begin
			pready_d = 1'b1;
			pslverr_d = !apb_hit;
			// Unmapped and write reads return zero
			prdata_d = (apb_hit && !pwrite) ? {24'h000000, flags_q} : 32'h00000000;
		end
	end

	// APB registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	// Condition test, return path select, bank decode
	always_comb begin
		// Decimal adjust and half carry are not testable
		case (cond_sel)
			psf_pkg::COND_ALWAYS: jump_d = 1'b1;
			psf_pkg::COND_CARRY: jump_d = flags_q[psf_pkg::BIT_CARRY];
			psf_pkg::COND_ZERO: jump_d = flags_q[psf_pkg::BIT_ZERO];
			psf_pkg::COND_SIGN: jump_d = flags_q[psf_pkg::BIT_SIGN];
			psf_pkg::COND_OVERFLOW: jump_d = flags_q[psf_pkg::BIT_OVERFLOW];
			default: jump_d = 1'b0;
		endcase
		jump_d = jump_d ^ cond_invert;
		// Fast return taken while the fast bit is set
		fast_ret_d = interrupt_return_instr
			&& flags_q[psf_pkg::BIT_FAST_INT];
		norm_ret_d = interrupt_return_instr && !flags_q[psf_pkg::BIT_FAST_INT];
		// Banked region only from E0 upward
		bank0_d = reg_addr_valid && (reg_addr >= psf_pkg::BANKED_REGION_BASE)
			&& !flags_q[psf_pkg::BIT_BANK];
		bank1_d = reg_addr_valid && (reg_addr >= psf_pkg::BANKED_REGION_BASE)
			&& flags_q[psf_pkg::BIT_BANK];
	end

	// Control output registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			jump_q <= 1'b0;
			fast_ret_q <= 1'b0;
			norm_ret_q <= 1'b0;
			bank0_q <= 1'b0;
			bank1_q <= 1'b0;
		end else begin
			jump_q <= jump_d;
			fast_ret_q <= fast_ret_d;
			norm_ret_q <= norm_ret_d;
			bank0_q <= bank0_d;
			bank1_q <= bank1_d;
		end
	end

	// ----------------------------------------------------------------
	// Output drive
	// ----------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign result = result_q;
	assign status_flags = flags_q;
	assign jump_taken = jump_q;
	assign irq_inhibit = flags_q[psf_pkg::BIT_FAST_INT];
	assign fast_return = fast_ret_q;
	assign normal_return = norm_ret_q;
	assign bank0_sel = bank0_q;
	assign bank1_sel = bank1_q;

endmodule : psf_status_flags

`default_nettype wire

//--- sim/psf_flags_checker.sv
// Purpose: Port assertions for the status flag block
// Assumes: Single clock, sync reset active high
// Notes: Bound onto every status flag instance at the foot
`timescale 1ns/1ps
`default_nettype none
module psf_flags_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic exec_valid,
	input wire logic flags_load,
	input wire logic select_bank_zero_instr,
	input wire logic select_bank_one_instr,
	input wire logic fast_int_enter,
	input wire logic interrupt_return_instr,
	input wire logic [2:0] cond_sel,
	input wire logic cond_invert,
	input wire logic [7:0] reg_addr,
	input wire logic reg_addr_valid,
	input wire logic [7:0] status_flags,
	input wire logic jump_taken,
	input wire logic irq_inhibit,
	input wire logic fast_return,
	input wire logic normal_return,
	input wire logic bank0_sel,
	input wire logic bank1_sel
);
	// ----------------------------------------------------------------
	// Clocking
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// Return kind follows the fast bit
	fast_ret_a: assert property (
		interrupt_return_instr && status_flags[1]
		|=> fast_return && !normal_return) else $error("No fast return");
	norm_ret_a: assert property (
		interrupt_return_instr && !status_flags[1]
		|=> normal_return && !fast_return) else $error("No normal return");
	irq_block_a: assert property (
		interrupt_return_instr && irq_inhibit && !fast_int_enter
		&& !flags_load |=> !irq_inhibit) else $error("Inhibit not released");
	fast_set_a: assert property (
		fast_int_enter && !flags_load |=> status_flags[1])
		else $error("Fast bit not set");
	// Bank bit and upper register decode
	bank_one_a: assert property (
		select_bank_one_instr && !select_bank_zero_instr |=> status_flags[0])
		else $error("Bank one not selected");
	bank_dec_a: assert property (
		reg_addr_valid && reg_addr >= 8'he0 |=> bank0_sel != bank1_sel)
		else $error("Bank decode wrong");
	bank_off_a: assert property (
		!reg_addr_valid |=> !bank0_sel && !bank1_sel)
		else $error("Bank decode without access");
	keep_flags_a: assert property (
		!(exec_valid || flags_load || select_bank_zero_instr ||
		select_bank_one_instr || fast_int_enter || interrupt_return_instr ||
		(psel && penable && pwrite)) |=> $stable(status_flags))
		else $error("Flags changed without cause");
	jump_sign_a: assert property (
		cond_sel == 3'h3 |=> jump_taken ==
		($past(status_flags[5]) ^ $past(cond_invert)))
		else $error("Sign jump wrong");
	apb_rdy_a: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("Ready not one cycle");
endmodule : psf_flags_checker
bind psf_status_flags psf_flags_checker i_psf_flags_checker (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .exec_valid(exec_valid),
	.flags_load(flags_load), .select_bank_zero_instr(select_bank_zero_instr),
	.select_bank_one_instr(select_bank_one_instr),
	.fast_int_enter(fast_int_enter),
	.interrupt_return_instr(interrupt_return_instr), .cond_sel(cond_sel),
	.cond_invert(cond_invert), .reg_addr(reg_addr),
	.reg_addr_valid(reg_addr_valid), .status_flags(status_flags),
	.jump_taken(jump_taken), .irq_inhibit(irq_inhibit),
	.fast_return(fast_return), .normal_return(normal_return),
	.bank0_sel(bank0_sel), .bank1_sel(bank1_sel));
`default_nettype wire

//--- sim/testbench.sv
// Purpose: Self-checking bench of the status flag block
// Assumes: APB with zero wait states, strobes one cycle wide
// Notes: Flags mirrored in ef, starting from the chosen reset of zero
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys, sys_rst, psel, penable, pwrite, exec_valid, flags_load;
	logic select_bank_zero_instr, select_bank_one_instr, fast_int_enter;
	logic interrupt_return_instr, cond_invert, reg_addr_valid, se;
	logic pready, pslverr, jump_taken, irq_inhibit, fast_return;
	logic normal_return, bank0_sel, bank1_sel;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [2:0] cond_sel;
	logic [7:0] operand_a, operand_b, flags_load_data, reg_addr;
	logic [7:0] result, status_flags, ef, er;
	logic [7:0] aa [3] = '{8'he0, 8'hff, 8'hdf};
	psf_pkg::psf_op_type exec_op;
	int n_mismatch, total_checks, i;
	psf_status_flags #(.PADDR_WIDTH(12)) i_psf_status_flags (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.exec_valid(exec_valid), .exec_op(exec_op), .operand_a(operand_a),
		.operand_b(operand_b), .flags_load(flags_load),
		.flags_load_data(flags_load_data),
		.select_bank_zero_instr(select_bank_zero_instr),
		.select_bank_one_instr(select_bank_one_instr),
		.fast_int_enter(fast_int_enter),
		.interrupt_return_instr(interrupt_return_instr),
		.cond_sel(cond_sel), .cond_invert(cond_invert), .reg_addr(reg_addr),
		.reg_addr_valid(reg_addr_valid), .result(result),
		.status_flags(status_flags), .jump_taken(jump_taken),
		.irq_inhibit(irq_inhibit), .fast_return(fast_return),
		.normal_return(normal_return), .bank0_sel(bank0_sel),
		.bank1_sel(bank1_sel));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, exp, input string w);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s got %h exp %h", $time, w, got, exp);
		end
	endtask : chk
	// Expected result and flags of one datapath operation
	function automatic logic [15:0] model(psf_pkg::psf_op_type op,
		logic [7:0] a, logic [7:0] b, logic [7:0] f);
		logic [8:0] r;
		logic c, v, h, d, cin;
		cin = (op == psf_pkg::OP_ADD_CARRY || op == psf_pkg::OP_SUB_CARRY) & f[7];
		{c, v, h, d} = {f[7], 1'b0, f[2], f[3]};
		case (op)
		psf_pkg::OP_ADD, psf_pkg::OP_ADD_CARRY: begin
			r = a + b + cin;
			h = (a[3:0] + b[3:0] + cin) > 5'd15;
			{c, d} = {r[8], 1'b0};
			v = (a[7] == b[7]) && (r[7] != a[7]);
		end
		psf_pkg::OP_SUB, psf_pkg::OP_SUB_CARRY: begin
			r = {1'b0, a} - b - cin;
			h = {1'b0, a[3:0]} < b[3:0] + cin;
			{c, d} = {r[8], 1'b1};
			v = (a[7] != b[7]) && (r[7] != a[7]);
		end
		psf_pkg::OP_AND: r = a & b;
		psf_pkg::OP_OR: r = a | b;
		psf_pkg::OP_XOR: r = a ^ b;
		psf_pkg::OP_BIT_TEST: r = a & b;
		psf_pkg::OP_ROTATE_LEFT_CARRY: begin
			{c, r[7:0]} = {a, f[7]};
			v = r[7] ^ a[7];
		end
		psf_pkg::OP_ROTATE_RIGHT_CARRY: begin
			{r[7:0], c} = {f[7], a};
			v = r[7] ^ a[7];
		end
		psf_pkg::OP_SHIFT_RIGHT_ARITH: {r[7:0], c} = {a[7], a};
		default: begin
			// Decimal adjust: add or subtract correction per last op kind
			if (!d) begin
				c = f[7] || a > 8'h99;
				r = a + (h || a[3:0] > 4'h9 ? 8'h06 : 8'h00) + (c ? 8'h60 : 8'h00);
			end else
				r = a - (h ? 8'h06 : 8'h00) - (c ? 8'h60 : 8'h00);
			v = f[4];
		end
		endcase
		return {r[7:0], c, r[7:0] == 8'h00, r[7], v, d, h, f[1:0]};
	endfunction : model
	// One APB transfer, held until ready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
		int n;
		@(posedge clk_sys);
		{psel, penable, pwrite} <= {2'b10, wr};
		paddr <= a;
		pwdata <= dt;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Request held until ready is seen high at a rising edge
		for (n = 0; n < 8; n++) begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		if (n == 8) begin
			n_mismatch++;
			finish_test();
		end
		{rd, se} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic run(input psf_pkg::psf_op_type op, input logic [7:0] a, b);
		logic [15:0] m;
		m = model(op, a, b, ef);
		// Bit test leaves the result register as it was
		if (op == psf_pkg::OP_BIT_TEST)
			m[15:8] = er;
		er = m[15:8];
		@(posedge clk_sys);
		{exec_valid, exec_op, operand_a, operand_b} <= {1'b1, op, a, b};
		@(posedge clk_sys);
		exec_valid <= 1'b0;
		@(negedge clk_sys);
		ef = m[7:0];
		chk(result, m[15:8], "result");
		chk(status_flags, ef, "flags");
	endtask : run
	// Pulse one instruction strobe: bank 0, bank 1, fast entry, return
	task automatic strobe(input int k);
		@(posedge clk_sys);
		case (k)
		0: select_bank_zero_instr <= 1'b1;
		1: select_bank_one_instr <= 1'b1;
		2: fast_int_enter <= 1'b1;
		default: interrupt_return_instr <= 1'b1;
		endcase
		@(posedge clk_sys);
		{select_bank_zero_instr, select_bank_one_instr} <= 2'b00;
		{fast_int_enter, interrupt_return_instr} <= 2'b00;
		@(negedge clk_sys);
	endtask : strobe
	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#2000000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		{sys_rst, psel, penable, pwrite, exec_valid, flags_load} = 6'h20;
		{select_bank_zero_instr, select_bank_one_instr, fast_int_enter} = 3'h0;
		{interrupt_return_instr, cond_invert, reg_addr_valid, cond_sel} = 6'h0;
		{paddr, pwdata, pstrb, operand_a, operand_b} = {44'h0, 4'hf, 16'h0};
		{flags_load_data, reg_addr, ef, er} = 32'h0;
		exec_op = psf_pkg::OP_ADD;
		{n_mismatch, total_checks} = 0;
		void'($urandom(53));
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(negedge clk_sys);
		apb(1'b0, 12'h354, 32'h0);
		chk(rd, 32'h0, "reset read");
		run(psf_pkg::OP_ADD, 8'h7f, 8'h01);
		run(psf_pkg::OP_ADD, 8'hff, 8'h01);
		run(psf_pkg::OP_SUB, 8'h80, 8'h01);
		run(psf_pkg::OP_SUB, 8'h10, 8'h01);
		run(psf_pkg::OP_ADD, 8'h09, 8'h08);
		run(psf_pkg::OP_DECIMAL_ADJUST, 8'h11, 8'h00);
		run(psf_pkg::OP_SUB, 8'h20, 8'h01);
		run(psf_pkg::OP_DECIMAL_ADJUST, 8'h1f, 8'h00);
		run(psf_pkg::OP_BIT_TEST, 8'hf0, 8'h0f);
		run(psf_pkg::OP_ROTATE_LEFT_CARRY, 8'h80, 8'h00);
		for (i = 0; i < 120; i++)
			run(psf_pkg::psf_op_type'($urandom_range(11)), 8'($urandom),
				8'($urandom));
		@(posedge clk_sys);
		{flags_load, flags_load_data} <= {1'b1, 8'ha4};
		@(posedge clk_sys);
		flags_load <= 1'b0;
		@(negedge clk_sys);
		ef = 8'ha4;
		chk(status_flags, ef, "load");
		apb(1'b1, 12'h354, 32'hff);
		ef[0] = 1'b1;
		apb(1'b0, 12'h354, 32'h0);
		chk(rd, {24'h0, ef}, "read back");
		apb(1'b1, 12'h358, 32'h0);
		@(negedge clk_sys);
		chk({se, status_flags}, {1'b1, ef}, "unmapped");
		for (i = 0; i < 6; i++) begin
			strobe(i % 2);
			ef[0] = 1'(i % 2);
			@(posedge clk_sys);
			{reg_addr_valid, reg_addr} <= {1'b1, aa[i / 2]};
			@(posedge clk_sys);
			reg_addr_valid <= 1'b0;
			@(negedge clk_sys);
			chk(status_flags, ef, "bank");
			chk({bank1_sel, bank0_sel}, aa[i / 2] < 8'he0 ? 0 : 1 + ef[0], "dec");
		end
		strobe(2);
		ef[1] = 1'b1;
		chk({irq_inhibit, status_flags}, {1'b1, ef}, "enter");
		strobe(3);
		ef[1] = 1'b0;
		chk({fast_return, normal_return, status_flags}, {2'b10, ef}, "fret");
		strobe(3);
		chk({fast_return, normal_return}, 32'h1, "normal return");
		for (i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			{cond_sel, cond_invert} <= 4'(i);
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk(jump_taken, (i < 2 ? 1'b1 : i > 9 ? 1'b0 : ef[8 - i / 2]) ^ i[0],
				"jump");
		end
		finish_test();
	end
endmodule : testbench
`default_nettype wire
